/* logic/ot_warn_vin_ov_fault_config.sv */
// Warning temperature limit, input overvoltage limit and response logic
`timescale 1ns/1ps
`default_nettype none
`include "ot_vin_defs.svh"
// Overview of operation
// - Warning word: exponent resets zero, mantissa restored
// - Unsupported warning limit write flags invalid data
// - Warning limit rounds to whole degree, 0-160
// - Warning limit of 255 disables warning
// - Warning limit releases faults, else 20-degree hysteresis
// - Input voltage at limit declares overvoltage fault
// - Overvoltage word: exponent resets 11110b, mantissa restored
// - Overvoltage limit 4-20 V, rounds to quarter volt
// - Out-of-range overvoltage limit write flags invalid data
// - Overvoltage fault sets three status bits, alerts host
// - Action: ignore, delayed, immediate shutdown; 11b invalid
// - Retry: latch, one to six tries, forever
// - Attempts during overvoltage still count as tries
// - Delay codes 0,1: one switching period
// - Overvoltage at enable blocks start even if ignored
// - Invalid response byte write flags invalid data
// - Temperature above warning sets warning bits, alerts
module ot_warn_vin_ov_fault_config
  import ot_vin_pkg::*;
#(
  parameter int RISE_W = 16
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic link_clk,
  input wire logic link_cmd_valid,
  input wire cmd_t link_cmd,
  output logic link_busy,
  output logic link_rsp_valid,
  output logic [15:0] link_rsp_data,
  input wire logic enable_pin,
  input wire logic signed [15:0] temperature,
  input wire logic [11:0] power_input_voltage,
  input wire logic signed [15:0] ot_fault_limit,
  input wire logic pwm_tick,
  input wire logic [RISE_W-1:0] output_rise_time,
  input wire logic start_done,
  input wire logic nvm_restore,
  input wire logic nvm_store,
  input wire logic [10:0] nvm_warn_temp_mantissa,
  input wire logic [10:0] nvm_input_ov_mantissa,
  input wire logic [7:0] nvm_ov_response,
  output logic [15:0] nvm_warn_image,
  output logic [15:0] nvm_ov_image,
  output logic switching_enable,
  output logic ov_latched,
  output logic signed [15:0] ot_release_threshold,
  output status_t status,
  output logic host_alert
);
  // ======
  // Helpers
  // Linear word to signed fixed point
  function automatic fix_t lin_fix(input logic [15:0] w);
    logic signed [4:0] e;
    fix_t m;
    int sh;
    e = w[`EXP_MSB:`EXP_LSB];
    m = fix_t'($signed(w[`MAN_MSB:`MAN_LSB]));
    sh = int'(e) + `FRAC_BITS;
    if (sh >= 0) begin
      lin_fix = m <<< sh;
    end else begin
      lin_fix = m >>> (-sh);
    end
  endfunction

  // Round to steps of 2^s units, clamp to [lo,hi]
  function automatic logic [10:0] round_step(input fix_t v, input int s, input fix_t lo, input fix_t hi);
    fix_t r;
    r = (v + (fix_t'(1) <<< (s - 1))) >>> s;
    if (r < lo) begin
      r = lo;
    end else if (r > hi) begin
      r = hi;
    end
    round_step = r[10:0];
  endfunction

  // Store-ready warning word; 255 stays as the disable code
  function automatic logic [15:0] warn_round(input logic [15:0] w);
    fix_t v;
    v = lin_fix(w);
    if (v == `WARN_OFF_FIX) begin
      warn_round = {`WARN_EXP_RST, 11'(`WARN_OFF_DEG)};
    end else begin
      warn_round = {`WARN_EXP_RST, round_step(v, `FRAC_BITS, `WARN_MIN_FIX, `WARN_MAX_DEG)};
    end
  endfunction

  // Store-ready overvoltage word in quarter volts
  function automatic logic [15:0] ov_round(input logic [15:0] w);
    ov_round = {`OV_EXP_RST, round_step(lin_fix(w), 2, `OV_MIN_QV, `OV_MAX_QV)};
  endfunction

  // ======
  // Reset, pin sync and link bridge
  logic rst_n;
  logic en_s;
  logic cmd_pulse;
  cmd_t cmd;
  logic rsp_done_ff;
  logic [15:0] rsp_data_ff;

  sync2 #(.W(1)) u_rst (.clk(mclk), .rst_n(arst_n), .d(1'b1), .q(rst_n));
  sync2 #(.W(1)) u_en (.clk(mclk), .rst_n(rst_n), .d(enable_pin), .q(en_s));

  link_cmd_bridge u_bridge (
    .link_clk(link_clk),
    .arst_n(arst_n),
    .link_cmd_valid(link_cmd_valid),
    .link_cmd(link_cmd),
    .link_busy(link_busy),
    .link_rsp_valid(link_rsp_valid),
    .link_rsp_data(link_rsp_data),
    .mclk(mclk),
    .rst_n(rst_n),
    .cmd_pulse(cmd_pulse),
    .cmd_held(cmd),
    .rsp_done(rsp_done_ff),
    .rsp_data(rsp_data_ff)
  );

  // ======
  // Register bank
  logic [15:0] overtemp_warning_limit_ff;
  logic [15:0] input_overvoltage_limit_ff;
  logic [7:0] input_overvoltage_response_ff;
  logic boot_ff;
  logic wr_warn;
  logic wr_ov;
  logic wr_resp;
  logic bad_write;
  fix_t wr_fix;

  // Write decode; rejected data is not stored
  always_comb begin
    wr_fix = lin_fix(cmd.data);
    wr_warn = 1'b0;
    wr_ov = 1'b0;
    wr_resp = 1'b0;
    bad_write = 1'b0;
    if (cmd_pulse && cmd.wr) begin
      case (cmd.code)
        `CMD_WARN_TEMP: begin
          wr_warn = (wr_fix >= `WARN_MIN_FIX && wr_fix <= `WARN_MAX_FIX) || wr_fix == `WARN_OFF_FIX;
          bad_write = !wr_warn;
        end
        `CMD_INPUT_OV_LIMIT: begin
          wr_ov = wr_fix >= `OV_MIN_FIX && wr_fix <= `OV_MAX_FIX;
          bad_write = !wr_ov;
        end
        `CMD_INPUT_OV_RESP: begin
          wr_resp = cmd.data[`ACT_MSB:`ACT_LSB] != `ACT_INVALID;
          bad_write = !wr_resp;
        end
        default: begin
        end
      endcase
    end
  end

  // Mantissas load from NVM after reset with fixed exponents; writes store the whole word, exponent included
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      boot_ff <= 1'b0;
      overtemp_warning_limit_ff <= {`WARN_EXP_RST, 11'h000};
      input_overvoltage_limit_ff <= {`OV_EXP_RST, 11'h000};
      input_overvoltage_response_ff <= 8'h00;
    end else begin
      boot_ff <= 1'b1;
      if (!boot_ff || nvm_restore) begin
        overtemp_warning_limit_ff <= warn_round({`WARN_EXP_RST, nvm_warn_temp_mantissa});
        input_overvoltage_limit_ff <= ov_round({`OV_EXP_RST, nvm_input_ov_mantissa});
        if (nvm_ov_response[`ACT_MSB:`ACT_LSB] != `ACT_INVALID) begin
          input_overvoltage_response_ff <= nvm_ov_response;
        end
      end else if (nvm_store) begin
        overtemp_warning_limit_ff <= warn_round(overtemp_warning_limit_ff);
        input_overvoltage_limit_ff <= ov_round(input_overvoltage_limit_ff);
      end else begin
        if (wr_warn) begin
          overtemp_warning_limit_ff <= cmd.data;
        end
        if (wr_ov) begin
          input_overvoltage_limit_ff <= cmd.data;
        end
        if (wr_resp) begin
          input_overvoltage_response_ff <= cmd.data[7:0];
        end
      end
    end
  end

  // Reply one cycle after each command; unknown codes read zero
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rsp_done_ff <= 1'b0;
      rsp_data_ff <= 16'h0000;
    end else begin
      rsp_done_ff <= cmd_pulse;
      if (cmd_pulse) begin
        case (cmd.code)
          `CMD_WARN_TEMP: rsp_data_ff <= overtemp_warning_limit_ff;
          `CMD_INPUT_OV_LIMIT: rsp_data_ff <= input_overvoltage_limit_ff;
          `CMD_INPUT_OV_RESP: rsp_data_ff <= {8'h00, input_overvoltage_response_ff};
          default: rsp_data_ff <= 16'h0000;
        endcase
      end
    end
  end

  // ======
  // Comparators
  fix_t warn_fix;
  fix_t ov_fix;
  fix_t fault_fix;
  logic warn_off;
  logic warn_now;
  logic ov_now;
  logic [1:0] ov_act;
  logic [2:0] ov_pol;
  logic [2:0] ov_dly;

  assign warn_fix = lin_fix(overtemp_warning_limit_ff);
  assign ov_fix = lin_fix(input_overvoltage_limit_ff);
  assign fault_fix = fix_t'(ot_fault_limit);
  assign warn_off = warn_fix == `WARN_OFF_FIX;
  assign warn_now = !warn_off && fix_t'(temperature) > warn_fix;
  assign ov_now = fix_t'({20'h0_0000, power_input_voltage}) >= ov_fix;
  assign ov_act = input_overvoltage_response_ff[`ACT_MSB:`ACT_LSB];
  assign ov_pol = input_overvoltage_response_ff[`POL_MSB:`POL_LSB];
  assign ov_dly = input_overvoltage_response_ff[`DLY_MSB:`DLY_LSB];

  // Release point for the fault block; a warning above the fault limit would never release
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ot_release_threshold <= 16'sh0000;
    end else if (warn_off || warn_fix > fault_fix) begin
      ot_release_threshold <= 16'(fault_fix - `HYST_FIX);
    end else begin
      ot_release_threshold <= 16'(warn_fix);
    end
  end

  // NVM images show what a store would keep
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      nvm_warn_image <= 16'h0000;
      nvm_ov_image <= 16'h0000;
    end else begin
      nvm_warn_image <= warn_round(overtemp_warning_limit_ff);
      nvm_ov_image <= ov_round(input_overvoltage_limit_ff);
    end
  end

  // ======
  // Status and alert; a live condition wins over a clear in the same cycle
  logic clear_req;
  assign clear_req = cmd_pulse && cmd.wr && cmd.code == `CMD_CLEAR_FAULTS;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      status <= '0;
      host_alert <= 1'b0;
    end else begin
      status.temp <= warn_now | (status.temp & ~clear_req);
      status.temp_warn <= warn_now | (status.temp_warn & ~clear_req);
      status.none_of_above <= ov_now | (status.none_of_above & ~clear_req);
      status.input_word <= ov_now | (status.input_word & ~clear_req);
      status.input_ov <= ov_now | (status.input_ov & ~clear_req);
      status.cml_invalid <= bad_write | (status.cml_invalid & ~clear_req);
      host_alert <= warn_now | ov_now | bad_write | (host_alert & ~clear_req);
    end
  end

  // ======
  // Overvoltage response and retry sequencer
  ov_state_t state_ff;
  ov_state_t nxt_state;
  logic [RISE_W-1:0] timer_ff;
  logic [2:0] attempts_ff;
  logic [2:0] nxt_attempts;
  logic attempt;
  logic shut;
  logic latch_now;

  assign nxt_attempts = (attempts_ff == 3'h7) ? attempts_ff : attempts_ff + 3'h1;
  assign latch_now = ov_pol == `POL_LATCH || (ov_pol != `POL_FOREVER && attempts_ff >= ov_pol);

  // Next state; enable low always returns to off
  always_comb begin
    nxt_state = state_ff;
    shut = 1'b0;
    attempt = 1'b0;
    case (state_ff)
      ST_OFF: begin
        if (en_s && !ov_now) begin
          nxt_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (ov_now && ov_act == `ACT_IMMEDIATE) begin
          shut = 1'b1;
        end else if (ov_now && ov_act == `ACT_DELAYED) begin
          nxt_state = ST_DELAY;
        end
      end
      ST_DELAY: begin
        if (!ov_now) begin
          nxt_state = ST_RUN;
        end else if (pwm_tick && timer_ff <= RISE_W'(1)) begin
          shut = 1'b1;
        end
      end
      ST_HICCUP: begin
        if (timer_ff == '0) begin
          attempt = 1'b1;
          if (!ov_now) begin
            nxt_state = ST_RUN;
          end else if (ov_pol != `POL_FOREVER && nxt_attempts >= ov_pol) begin
            nxt_state = ST_LATCHED;
          end
        end
      end
      ST_LATCHED: begin
      end
      default: nxt_state = ST_OFF;
    endcase
    if (shut) begin
      nxt_state = latch_now ? ST_LATCHED : ST_HICCUP;
    end
    if (!en_s) begin
      nxt_state = ST_OFF;
    end
  end

  // State and switching gate
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ST_OFF;
      switching_enable <= 1'b0;
      ov_latched <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      switching_enable <= nxt_state == ST_RUN || nxt_state == ST_DELAY;
      ov_latched <= nxt_state == ST_LATCHED;
    end
  end

  // Delay counts switching periods, hiccup mclk cycles
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      timer_ff <= '0;
    end else if (nxt_state == ST_DELAY && state_ff != ST_DELAY) begin
      timer_ff <= (ov_dly <= `DLY_MIN_TICKS) ? RISE_W'(1) : RISE_W'(ov_dly);
    end else if (nxt_state == ST_HICCUP && (state_ff != ST_HICCUP || attempt)) begin
      timer_ff <= output_rise_time;
    end else if (state_ff == ST_DELAY && pwm_tick && timer_ff != '0) begin
      timer_ff <= timer_ff - RISE_W'(1);
    end else if (state_ff == ST_HICCUP && timer_ff != '0) begin
      timer_ff <= timer_ff - RISE_W'(1);
    end
  end

  // Every attempt counts; good start or off starts afresh
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      attempts_ff <= 3'h0;
    end else if (!en_s || (state_ff == ST_RUN && start_done && !ov_now)) begin
      attempts_ff <= 3'h0;
    end else if (attempt) begin
      attempts_ff <= nxt_attempts;
    end
  end
endmodule
`default_nettype wire

/* include/ot_vin_defs.svh */
// Codes, field positions, resets and limits for the limit bank
`ifndef OT_VIN_DEFS_SVH
`define OT_VIN_DEFS_SVH
`define CMD_CLEAR_FAULTS 8'h03
`define CMD_WARN_TEMP 8'h51
`define CMD_INPUT_OV_LIMIT 8'h55
`define CMD_INPUT_OV_RESP 8'h56
`define EXP_MSB 15
`define EXP_LSB 11
`define MAN_MSB 10
`define MAN_LSB 0
`define ACT_MSB 7
`define ACT_LSB 6
`define POL_MSB 5
`define POL_LSB 3
`define DLY_MSB 2
`define DLY_LSB 0
`define WARN_EXP_RST 5'h00
`define OV_EXP_RST 5'h1E
`define FRAC_BITS 4
`define WARN_MIN_FIX 32'h0000_0000
`define WARN_MAX_FIX 32'h0000_0A00
`define WARN_OFF_FIX 32'h0000_0FF0
`define WARN_MAX_DEG 32'h0000_00A0
`define WARN_OFF_DEG 32'h0000_00FF
`define HYST_FIX 32'h0000_0140
`define OV_MIN_FIX 32'h0000_0040
`define OV_MAX_FIX 32'h0000_0140
`define OV_MIN_QV 32'h0000_0010
`define OV_MAX_QV 32'h0000_0050
`define ACT_IGNORE 2'h0
`define ACT_DELAYED 2'h1
`define ACT_IMMEDIATE 2'h2
`define ACT_INVALID 2'h3
`define POL_LATCH 3'h0
`define POL_FOREVER 3'h7
`define DLY_MIN_TICKS 3'h1
`endif

/* include/ot_vin_pkg.sv */
// Types shared by the limit bank and its bench
package ot_vin_pkg;
  typedef logic signed [31:0] fix_t;
  typedef struct packed {
    logic [7:0] code;
    logic wr;
    logic [15:0] data;
  } cmd_t;
  typedef struct packed {
    logic cml_invalid;
    logic temp;
    logic none_of_above;
    logic input_word;
    logic input_ov;
    logic temp_warn;
  } status_t;
  typedef enum logic [2:0] {ST_OFF, ST_RUN, ST_DELAY, ST_HICCUP, ST_LATCHED} ov_state_t;
endpackage

/* logic/sync2.sv */
// Two-flop synchroniser, also used to release resets
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_ff;

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= '0;
      q <= '0;
    end else begin
      meta_ff <= d;
      q <= meta_ff;
    end
  end
endmodule
`default_nettype wire

/* logic/link_cmd_bridge.sv */
// Toggle handshake: commands to mclk, answers back
`timescale 1ns/1ps
`default_nettype none
module link_cmd_bridge
  import ot_vin_pkg::*;
(
  input wire logic link_clk,
  input wire logic arst_n,
  input wire logic link_cmd_valid,
  input wire cmd_t link_cmd,
  output logic link_busy,
  output logic link_rsp_valid,
  output logic [15:0] link_rsp_data,
  input wire logic mclk,
  input wire logic rst_n,
  output logic cmd_pulse,
  output cmd_t cmd_held,
  input wire logic rsp_done,
  input wire logic [15:0] rsp_data
);
  // ======
  // Link domain
  logic lrst_n;
  logic ack_tgl_ff;
  logic ack_s;
  logic ack_seen_ff;
  logic req_tgl_ff;
  logic busy_ff;
  cmd_t cmd_ff;

  sync2 #(.W(1)) u_lrst (.clk(link_clk), .rst_n(arst_n), .d(1'b1), .q(lrst_n));
  sync2 #(.W(1)) u_ack (.clk(link_clk), .rst_n(lrst_n), .d(ack_tgl_ff), .q(ack_s));

  // Hold a command; new ones are dropped while busy
  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      cmd_ff <= '0;
      req_tgl_ff <= 1'b0;
      busy_ff <= 1'b0;
    end else if (link_cmd_valid && !busy_ff) begin
      cmd_ff <= link_cmd;
      req_tgl_ff <= ~req_tgl_ff;
      busy_ff <= 1'b1;
    end else if (ack_s != ack_seen_ff) begin
      busy_ff <= 1'b0;
    end
  end

  // Answer returns as a toggle; mclk holds the reply word
  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      ack_seen_ff <= 1'b0;
      link_rsp_valid <= 1'b0;
      link_rsp_data <= 16'h0000;
    end else begin
      ack_seen_ff <= ack_s;
      link_rsp_valid <= (ack_s != ack_seen_ff);
      if (ack_s != ack_seen_ff) begin
        link_rsp_data <= rsp_data;
      end
    end
  end

  assign link_busy = busy_ff;
  assign cmd_held = cmd_ff;

  // ======
  // Core domain
  logic req_s;
  logic req_seen_ff;

  sync2 #(.W(1)) u_req (.clk(mclk), .rst_n(rst_n), .d(req_tgl_ff), .q(req_s));

  // Toggle edge marks a new held command
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      req_seen_ff <= 1'b0;
      ack_tgl_ff <= 1'b0;
    end else begin
      req_seen_ff <= req_s;
      if (rsp_done) begin
        ack_tgl_ff <= ~ack_tgl_ff;
      end
    end
  end

  assign cmd_pulse = req_s ^ req_seen_ff;
endmodule
`default_nettype wire

/* sim/ov_cfg_checker.sv */
// Checks on the limit bank's core outputs
`timescale 1ns/1ps
`default_nettype none
module ov_cfg_checker
  import ot_vin_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic enable_pin,
  input wire logic signed [15:0] ot_fault_limit,
  input wire logic signed [15:0] ot_release_threshold,
  input wire logic switching_enable,
  input wire logic ov_latched,
  input wire status_t status,
  input wire logic host_alert
);
  // ==========================================
  // One clock domain
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // ==========================================
  // Status and alert relations
  AST_OV_STATUS: assert property ($rose(status.input_ov) |->
    ##[0:1] (status.none_of_above && status.input_word && host_alert)) else $error("ov status bits incomplete");
  AST_WARN_STATUS: assert property ($rose(status.temp_warn) |-> ##[0:1] (status.temp && host_alert))
    else $error("warning status incomplete");
  AST_INVALID_ALERT: assert property ($rose(status.cml_invalid) |-> ##[0:1] host_alert)
    else $error("invalid data without alert");
  AST_ALERT_CAUSE: assert property ($rose(host_alert) |-> ##[0:1] (status != '0))
    else $error("alert without any flag");
  // Release threshold not above fault limit
  AST_RELEASE_BELOW: assert property ($stable(ot_fault_limit) |-> ot_release_threshold <= ot_fault_limit)
    else $error("release threshold above fault limit");
  // ==========================================
  // Sequencer; enable passes a two-flop sync
  AST_LATCH_STOPS: assert property (ov_latched && $past(ov_latched) |-> !switching_enable)
    else $error("switching while latched off");
  AST_LATCH_HOLDS: assert property ((enable_pin [*4] ##0 ov_latched) |=> ov_latched)
    else $error("latch left while enabled");
  AST_OFF_STOPS: assert property ($fell(enable_pin) |-> ##[1:6] !switching_enable)
    else $error("switching kept after off");
  AST_START_NEEDS_EN: assert property ($rose(switching_enable) |-> $past(enable_pin, 3))
    else $error("start without enable");
  // Main scenarios reached
  cover property ($rose(ov_latched));
  cover property ($rose(status.temp_warn));
  cover property ($rose(status.cml_invalid));
endmodule
bind ot_warn_vin_ov_fault_config ov_cfg_checker i_ov_cfg_checker (.mclk(mclk), .arst_n(arst_n),
  .enable_pin(enable_pin), .ot_fault_limit(ot_fault_limit), .ot_release_threshold(ot_release_threshold),
  .switching_enable(switching_enable), .ov_latched(ov_latched), .status(status), .host_alert(host_alert));
`default_nettype wire

/* sim/link_host.sv */
// Link-side host issuing register commands
`timescale 1ns/1ps
`default_nettype none
module link_host
  import ot_vin_pkg::*;
(
  input wire logic link_clk,
  output logic link_cmd_valid,
  output cmd_t link_cmd,
  input wire logic link_busy,
  input wire logic link_rsp_valid,
  input wire logic [15:0] link_rsp_data
);
  initial begin
    link_cmd_valid = 1'b0;
    link_cmd = '0;
  end
  // Command held for the taking edge; idle lines show the inverse
  task automatic xfer(input logic [7:0] code, input logic wr, input logic [15:0] data, output logic [15:0] rsp);
    @(posedge link_clk);
    link_cmd_valid <= 1'b1;
    link_cmd <= '{code, wr, data};
    @(posedge link_clk);
    link_cmd_valid <= 1'b0;
    link_cmd <= ~link_cmd;
    do @(negedge link_clk); while (link_rsp_valid !== 1'b1);
    rsp = link_rsp_data;
  endtask
endmodule
`default_nettype wire

/* sim/testbench.sv */
// Self-checking bench for the limit bank
`timescale 1ns/1ps
`default_nettype none
module testbench
  import ot_vin_pkg::*;
;
  localparam logic [11:0] VIN_SAFE = 12'h0FF;
  localparam logic [11:0] VIN_OVER = 12'h100;
  logic mclk, link_clk, arst_n, enable_pin, start_done, nvm_restore, nvm_store, pwm_tick;
  logic link_cmd_valid, link_busy, link_rsp_valid, switching_enable, ov_latched, host_alert;
  logic signed [15:0] temperature, ot_release_threshold, ot_fault_limit;
  logic [11:0] power_input_voltage;
  logic [15:0] link_rsp_data, nvm_warn_image, nvm_ov_image;
  cmd_t link_cmd;
  status_t status;
  logic [2:0] tick_cnt = 3'h0;
  int n_errors, samples_checked;
  // ==========================================
  // Clocks and switching tick, one tick every eight cycles
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #80 link_clk = ~link_clk;
  end
  always @(negedge mclk) tick_cnt <= tick_cnt + 3'h1;
  assign pwm_tick = (tick_cnt == 3'h7);
  ot_warn_vin_ov_fault_config i_ot_warn_vin_ov_fault_config (.mclk(mclk), .arst_n(arst_n),
    .link_clk(link_clk), .link_cmd_valid(link_cmd_valid), .link_cmd(link_cmd), .link_busy(link_busy),
    .link_rsp_valid(link_rsp_valid), .link_rsp_data(link_rsp_data), .enable_pin(enable_pin),
    .temperature(temperature), .power_input_voltage(power_input_voltage), .ot_fault_limit(ot_fault_limit),
    .pwm_tick(pwm_tick), .output_rise_time(16'h0014), .start_done(start_done), .nvm_restore(nvm_restore),
    .nvm_store(nvm_store), .nvm_warn_temp_mantissa(11'h055), .nvm_input_ov_mantissa(11'h040),
    .nvm_ov_response(8'h80), .nvm_warn_image(nvm_warn_image), .nvm_ov_image(nvm_ov_image),
    .switching_enable(switching_enable), .ov_latched(ov_latched),
    .ot_release_threshold(ot_release_threshold), .status(status), .host_alert(host_alert));
  link_host host (.link_clk(link_clk), .link_cmd_valid(link_cmd_valid), .link_cmd(link_cmd),
    .link_busy(link_busy), .link_rsp_valid(link_rsp_valid), .link_rsp_data(link_rsp_data));
  // ==========================================
  // Shared helpers
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic chk1(input string what, input logic exp, input logic got);
    chk(what, {15'h0000, exp}, {15'h0000, got});
  endtask
  task automatic wr(input logic [7:0] code, input logic [15:0] data);
    logic [15:0] r;
    host.xfer(code, 1'b1, data, r);
    cyc(1);
  endtask
  task automatic rd(input logic [7:0] code, input logic [15:0] exp);
    logic [15:0] r;
    host.xfer(code, 1'b0, 16'h0000, r);
    cyc(1);
    chk("read word", exp, r);
  endtask
  task automatic wait_run();
    int n;
    n = 0;
    while (switching_enable !== 1'b1 && n < 60) begin
      cyc(1);
      n++;
    end
    chk1("switching on", 1'b1, switching_enable);
  endtask
  task automatic latch_time(output int n);
    n = 0;
    while (ov_latched !== 1'b1 && n < 300) begin
      cyc(1);
      n++;
    end
  endtask
  task automatic restart();
    enable_pin = 1'b0;
    power_input_voltage = VIN_SAFE;
    cyc(10);
    chk1("latched after off", 1'b0, ov_latched);
    enable_pin = 1'b1;
    wait_run();
  endtask
  // ==========================================
  // Scenarios
  task automatic t_invalid();
    logic [7:0] cd [7] = '{8'h51, 8'h51, 8'h55, 8'h55, 8'h55, 8'h56, 8'h56};
    logic [15:0] dt [7] = '{16'h00A1, 16'h00A0, 16'hF00F, 16'hF050, 16'hF051, 16'h00C0, 16'h0098};
    logic bad [7] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
    logic [15:0] rb [7] = '{16'h0055, 16'h00A0, 16'hF040, 16'hF050, 16'hF050, 16'h0080, 16'h0098};
    for (int i = 0; i < 7; i++) begin
      wr(8'h03, 16'h0000);
      wr(cd[i], dt[i]);
      chk1("invalid flag", bad[i], status.cml_invalid);
      chk1("alert", bad[i], host_alert);
      rd(cd[i], rb[i]);
    end
    $display("limit range test done");
  endtask
  task automatic t_round();
    wr(8'h51, 16'hF191);
    wr(8'h55, 16'hE0C1);
    nvm_store = 1'b1;
    cyc(1);
    nvm_store = 1'b0;
    cyc(4);
    chk("warn image", 16'h0064, nvm_warn_image);
    chk("ov image", 16'hF030, nvm_ov_image);
    rd(8'h51, 16'h0064);
    rd(8'h55, 16'hF030);
    nvm_restore = 1'b1;
    cyc(1);
    nvm_restore = 1'b0;
    cyc(4);
    rd(8'h51, 16'h0055);
    rd(8'h55, 16'hF040);
    rd(8'h56, 16'h0080);
    $display("rounding test done");
  endtask
  task automatic t_warn();
    wr(8'h51, 16'h005A);
    chk("threshold", 16'h05A0, ot_release_threshold);
    temperature = 16'sh05A0;
    cyc(4);
    wr(8'h03, 16'h0000);
    chk1("warn at limit", 1'b0, status.temp_warn);
    temperature = 16'sh05A1;
    cyc(4);
    chk1("warn above", 1'b1, status.temp_warn);
    chk1("temp bit", 1'b1, status.temp);
    chk1("warn alert", 1'b1, host_alert);
    wr(8'h51, 16'h00FF);
    wr(8'h03, 16'h0000);
    cyc(4);
    chk1("warn disabled", 1'b0, status.temp_warn);
    chk("threshold default", 16'h0640, ot_release_threshold);
    ot_fault_limit = 16'sh0A00;
    cyc(2);
    chk("threshold fault", 16'h08C0, ot_release_threshold);
    ot_fault_limit = 16'sh0780;
    temperature = 16'sh0190;
    $display("warning test done");
  endtask
  task automatic t_ov();
    int n;
    wr(8'h56, 16'h0000);
    power_input_voltage = VIN_OVER;
    enable_pin = 1'b1;
    cyc(40);
    chk1("start blocked", 1'b0, switching_enable);
    chk1("ov flag", 1'b1, status.input_ov);
    chk1("none of above", 1'b1, status.none_of_above);
    chk1("input bit", 1'b1, status.input_word);
    power_input_voltage = VIN_SAFE;
    wait_run();
    wr(8'h03, 16'h0000);
    chk1("below limit", 1'b0, status.input_ov);
    power_input_voltage = VIN_OVER;
    cyc(20);
    chk1("ignored fault", 1'b1, switching_enable);
    power_input_voltage = VIN_SAFE;
    wr(8'h56, 16'h0090);
    power_input_voltage = VIN_OVER;
    cyc(4);
    chk1("immediate shut", 1'b0, switching_enable);
    latch_time(n);
    chk1("two tries span", 1'b1, n >= 34 && n <= 50);
    restart();
    power_input_voltage = VIN_OVER;
    cyc(4);
    power_input_voltage = VIN_SAFE;
    wait_run();
    start_done = 1'b1;
    cyc(1);
    start_done = 1'b0;
    power_input_voltage = VIN_OVER;
    cyc(4);
    latch_time(n);
    chk1("fresh tries span", 1'b1, n >= 34 && n <= 50);
    restart();
    $display("overvoltage test done");
  endtask
  task automatic t_delay();
    int n;
    for (int d = 0; d < 2; d++) begin
      wr(8'h56, 16'h0040 | d[15:0]);
      while (pwm_tick !== 1'b1) cyc(1);
      cyc(1);
      power_input_voltage = VIN_OVER;
      cyc(4);
      chk1("delayed keeps on", 1'b1, switching_enable);
      latch_time(n);
      chk1("one period delay", 1'b1, n >= 2 && n <= 12);
      restart();
    end
    $display("delay test done");
  endtask
  // ==========================================
  // Verdict, counts and run end
  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    #2_000_000;
    n_errors++;
    $display("watchdog expired");
    wrap_up();
  end
  // Reset, then boot values
  initial begin
    n_errors = 0;
    samples_checked = 0;
    arst_n = 1'b0;
    enable_pin = 1'b0;
    start_done = 1'b0;
    nvm_restore = 1'b0;
    nvm_store = 1'b0;
    temperature = 16'sh0190;
    power_input_voltage = VIN_SAFE;
    ot_fault_limit = 16'sh0780;
    cyc(4);
    arst_n = 1'b1;
    repeat (6) @(posedge link_clk);
    cyc(1);
    rd(8'h51, 16'h0055);
    rd(8'h55, 16'hF040);
    rd(8'h56, 16'h0080);
    t_invalid();
    t_round();
    t_warn();
    t_ov();
    t_delay();
    wrap_up();
  end
endmodule
`default_nettype wire
